// ==== core/bkr_regs.svh ====
// Operation
// - With the keep-alive bit at 0 the regulator turns off once the hold pin is low and the push button is released high.
// - With the keep-alive bit at 1 the regulator stays on although the hold pin is low and the push button is released high.
// - A disabled regulator has its output discharged only when the discharge bit is 1.
// - Codes 0 to 31 give 0.800 V plus 25 mV per code, and from code 32 (1.600 V) each code adds 50 mV, 1.950 V at code 39.
// - A downward step of any size in one bus write is accepted and never flagged.
// - On external-divider variants the voltage field is stored but does not move the regulator setpoint.
// - All eight bits are read/write and reload their defaults on undervoltage lockout or device reset.
`ifndef BKR_REGS_SVH
`define BKR_REGS_SVH

// register address
`define BKR_OUTPUT_CONFIG_ADDR    8'h07

// field positions
`define BKR_KEEP_ALIVE_BIT        7
`define BKR_DISCHARGE_BIT         6
`define BKR_CODE_MSB              5
`define BKR_CODE_LSB              0

// per-variant reset values of the whole register
`define BKR_DEFAULT_DIVIDER       8'h29
`define BKR_DEFAULT_FIXED_A       8'h25
`define BKR_DEFAULT_FIXED_B       8'h26

// voltage decode, millivolts
`define BKR_LOW_BASE_MV           12'h320
`define BKR_LOW_STEP_MV           12'h019
`define BKR_HIGH_BASE_MV          12'h640
`define BKR_HIGH_STEP_MV          12'h032
`define BKR_HIGH_RANGE_CODE       6'h20

// upward step limit, percent
`define BKR_STEP_LIMIT_PCT        19'h0006C
`define BKR_PCT_SCALE             19'h00064

// unmapped reads
`define BKR_UNMAPPED_DATA         8'h00

`endif

// ==== core/bkr_pkg.sv ====
package bkr_pkg;

	// device variant: how the output voltage is set
	typedef enum logic [1:0] {
		BKR_VAR_DIVIDER,
		BKR_VAR_FIXED_A,
		BKR_VAR_FIXED_B
	} bkr_variant_t;

	// contents of the output configuration register
	typedef struct packed {
		logic       keep_alive;
		logic       discharge;
		logic [5:0] code;
	} bkr_cfg_t;

	// regulator power state
	typedef enum logic {
		BKR_REG_ON,
		BKR_REG_OFF
	} bkr_reg_state_t;

	// register access request from the serial interface engine
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bkr_req_t;

endpackage : bkr_pkg

// ==== core/bkr_config_reg.sv ====
`timescale 1ns/1ps
`include "bkr_regs.svh"

module bkr_config_reg
	import bkr_pkg::*;
#(
	parameter bkr_variant_t VARIANT = BKR_VAR_DIVIDER
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// undervoltage lockout level
	input  wire logic       undervoltage_lockout,
	// register access from the serial interface engine
	input  wire bkr_req_t   reg_req,
	output logic [7:0]      reg_rdata_ff,
	output logic            reg_ack_ff,
	// power control pins
	input  wire logic       hold_pin,
	input  wire logic       push_button_input,
	// regulator controls
	output logic            regulator_on_ff,
	output logic            discharge_on_ff,
	output logic [11:0]     setpoint_mv_ff,
	output logic            step_over_limit_ff
);

	// reset value for the chosen variant
	localparam logic [7:0] DEFAULT_VALUE =
		(VARIANT == BKR_VAR_FIXED_A) ? `BKR_DEFAULT_FIXED_A :
		(VARIANT == BKR_VAR_FIXED_B) ? `BKR_DEFAULT_FIXED_B : `BKR_DEFAULT_DIVIDER;
	localparam logic       EXT_DIVIDER   = (VARIANT == BKR_VAR_DIVIDER);

	// code to millivolts, two ranges
	function automatic logic [11:0] code_to_mv(input logic [5:0] code);
		logic [11:0] steps;
		steps = {6'h00, code};
		if (code < `BKR_HIGH_RANGE_CODE) begin
			code_to_mv = `BKR_LOW_BASE_MV + 12'(steps * `BKR_LOW_STEP_MV);
		end else begin
			code_to_mv = `BKR_HIGH_BASE_MV
				+ 12'((steps - 12'h020) * `BKR_HIGH_STEP_MV);
		end
	endfunction : code_to_mv

	// address match for the configuration register
	function automatic logic is_cfg_addr(input logic [7:0] addr);
		is_cfg_addr = (addr == `BKR_OUTPUT_CONFIG_ADDR);
	endfunction : is_cfg_addr

	// read data for one address; unmapped addresses read as a constant
	function automatic logic [7:0] read_mux(input logic [7:0] addr, input bkr_cfg_t cfg);
		if (is_cfg_addr(addr)) begin
			read_mux = cfg;
		end else begin
			read_mux = `BKR_UNMAPPED_DATA;
		end
	endfunction : read_mux

	// true when the new code lifts the setpoint past the allowed upward step
	function automatic logic step_too_big(input logic [5:0] old_code,
		input logic [5:0] new_code);
		logic [18:0] old_lim;
		logic [18:0] new_val;
		old_lim      = 19'(code_to_mv(old_code) * `BKR_STEP_LIMIT_PCT);
		new_val      = 19'(code_to_mv(new_code) * `BKR_PCT_SCALE);
		step_too_big = (new_val > old_lim);  // down steps never exceed the limit
	endfunction : step_too_big

	// setpoint held by divider variants and loaded at reset
	localparam logic [11:0] DEFAULT_MV =
		code_to_mv(DEFAULT_VALUE[`BKR_CODE_MSB:`BKR_CODE_LSB]);

	// register contents
	bkr_cfg_t       cfg_ff;
	bkr_cfg_t       nxt_cfg;
	logic           cfg_wr_hit;
	// read port
	logic [7:0]     nxt_reg_rdata;
	logic           nxt_reg_ack;
	// regulator control
	bkr_reg_state_t state_ff;
	bkr_reg_state_t nxt_state;
	logic           nxt_regulator_on;
	logic           nxt_discharge_on;
	logic [11:0]    nxt_setpoint_mv;
	logic           nxt_step_over_limit;

	// a host write that lands in the register; lockout blocks it
	assign cfg_wr_hit = reg_req.wr_en && is_cfg_addr(reg_req.addr) && !undervoltage_lockout;

	// register contents: lockout reload beats a host write
	always_comb begin
		nxt_cfg = cfg_ff;
		if (undervoltage_lockout) begin
			nxt_cfg = bkr_cfg_t'(DEFAULT_VALUE);
		end else if (cfg_wr_hit) begin
			nxt_cfg = bkr_cfg_t'(reg_req.wdata);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cfg_ff <= bkr_cfg_t'(DEFAULT_VALUE);
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	// read data and acknowledge; a read sees the value before a same-cycle write
	always_comb begin
		nxt_reg_rdata = reg_rdata_ff;  // held until the next read
		nxt_reg_ack   = reg_req.wr_en | reg_req.rd_en;
		if (reg_req.rd_en) begin
			nxt_reg_rdata = read_mux(reg_req.addr, cfg_ff);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg_rdata_ff <= 8'h00;
			reg_ack_ff   <= 1'b0;
		end else begin
			reg_rdata_ff <= nxt_reg_rdata;
			reg_ack_ff   <= nxt_reg_ack;
		end
	end

	// regulator power state: released by the pins, held on by keep-alive
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			BKR_REG_ON: begin
				if (!hold_pin && push_button_input && !cfg_ff.keep_alive) begin
					nxt_state = BKR_REG_OFF;
				end else begin
					nxt_state = BKR_REG_ON;
				end
			end
			BKR_REG_OFF: begin
				if (hold_pin || cfg_ff.keep_alive) begin
					nxt_state = BKR_REG_ON;  // back on once held again
				end
			end
			default: begin
				nxt_state = BKR_REG_ON;  // recover from an illegal state
			end
		endcase
		// lockout always wins over the pins
		if (undervoltage_lockout) begin
			nxt_state = BKR_REG_OFF;
		end
		nxt_regulator_on = (nxt_state == BKR_REG_ON);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff        <= BKR_REG_ON;
			regulator_on_ff <= 1'b1;
		end else begin
			state_ff        <= nxt_state;
			regulator_on_ff <= nxt_regulator_on;
		end
	end

	// output discharge follows the off state and the stored bit
	always_comb begin
		nxt_discharge_on = 1'b0;
		if (nxt_state == BKR_REG_OFF) begin
			nxt_discharge_on = nxt_cfg.discharge;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			discharge_on_ff <= 1'b0;
		end else begin
			discharge_on_ff <= nxt_discharge_on;
		end
	end

	// setpoint: divider variants keep the default, fixed ones follow the code
	always_comb begin
		if (EXT_DIVIDER) begin
			nxt_setpoint_mv = DEFAULT_MV;
		end else begin
			nxt_setpoint_mv = code_to_mv(nxt_cfg.code);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			setpoint_mv_ff <= DEFAULT_MV;
		end else begin
			setpoint_mv_ff <= nxt_setpoint_mv;
		end
	end

	// step flag: only upward steps past the limit raise it, for one cycle
	always_comb begin
		nxt_step_over_limit = 1'b0;
		if (cfg_wr_hit
			&& step_too_big(cfg_ff.code, reg_req.wdata[`BKR_CODE_MSB:`BKR_CODE_LSB])) begin
			nxt_step_over_limit = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			step_over_limit_ff <= 1'b0;
		end else begin
			step_over_limit_ff <= nxt_step_over_limit;
		end
	end

endmodule : bkr_config_reg

// ==== tb/bkr_host.sv ====
`timescale 1ns/1ps
module bkr_host
	import bkr_pkg::*;
(
	// engine side
	input wire logic	core_clk,
	output bkr_req_t	reg_req
);
	initial reg_req = '0;
	// one access held over its taking edge
	task automatic xfer(input logic w, input logic [7:0] d);
		@(posedge core_clk) #1;
		reg_req = {w, !w, 8'h07, d};
		@(posedge core_clk) #1;
		reg_req = {2'h0, ~{8'h07, d}};
	endtask : xfer
endmodule : bkr_host

// ==== tb/bkr_cfg_properties.sv ====
`timescale 1ns/1ps
module bkr_props
	import bkr_pkg::*;
(
	// clock, reset, pins
	input wire logic	core_clk,
	input wire logic	reset,
	input wire logic	undervoltage_lockout,
	input wire logic	hold_pin,
	input wire logic	push_button_input,
	// register port, regulator
	input wire bkr_req_t	reg_req,
	input wire logic [7:0]	reg_rdata_ff,
	input wire logic	reg_ack_ff,
	input wire logic	regulator_on_ff,
	input wire logic	discharge_on_ff,
	input wire logic [11:0]	setpoint_mv_ff,
	input wire logic	step_over_limit_ff
);
	logic [1:0]	sh_ff;
	logic		wr;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// mirror of keep-alive and discharge bits
	assign wr = reg_req.wr_en && reg_req.addr == 8'h07 && !undervoltage_lockout;
	always_ff @(posedge core_clk)
		sh_ff <= (reset || undervoltage_lockout) ? 2'h0 : (wr ? reg_req.wdata[7:6] : sh_ff);
	a_rel_off: assert property (
		!sh_ff[1] && !hold_pin && push_button_input |=> !regulator_on_ff) else $error("on");
	a_keep_on: assert property (
		sh_ff[1] && regulator_on_ff && !undervoltage_lockout |=> regulator_on_ff) else $error("off");
	a_dis_bit: assert property (
		!regulator_on_ff && $stable(sh_ff) |-> discharge_on_ff == sh_ff[0]) else $error("dis");
	a_dis_off: assert property (discharge_on_ff |-> !regulator_on_ff) else $error("dis on");
	a_down_ok: assert property (
		$past(wr) && setpoint_mv_ff <= $past(setpoint_mv_ff) |-> !step_over_limit_ff) else $error("up");
	a_sp_why: assert property (
		$changed(setpoint_mv_ff) |-> $past(wr || undervoltage_lockout)) else $error("sp");
	a_read: assert property (
		$past(reg_req.rd_en && !wr && reg_req.addr == 8'h07) |-> reg_ack_ff
		&& reg_rdata_ff[7:6] == $past(sh_ff)) else $error("rd");
	a_rst: assert property ($fell(reset) |-> regulator_on_ff && !reg_ack_ff) else $error("rst");
	// main scenarios
	c_off: cover property ($fell(regulator_on_ff));
	c_up: cover property (step_over_limit_ff);
	c_uvlo: cover property ($fell(undervoltage_lockout));
endmodule : bkr_props

bind bkr_config_reg bkr_props bkr_props_i (.*);

// ==== tb/tb_buck_regulator_config_register.sv ====
`timescale 1ns/1ps
module tb_buck_regulator_config_register
	import bkr_pkg::*;
;
	logic		core_clk, reset, undervoltage_lockout, hold_pin, push_button_input;
	logic		reg_ack_ff, regulator_on_ff, discharge_on_ff, step_over_limit_ff;
	logic [7:0]	reg_rdata_ff;
	logic [11:0]	setpoint_mv_ff;
	bkr_req_t	reg_req;
	int		error_cnt = 0, num_checks = 0;
	// host model and block
	bkr_host bkr_host_i (.*);
	bkr_config_reg #(.VARIANT(BKR_VAR_FIXED_A)) bkr_config_reg_i (.*);
	// compare and count
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		num_checks++;
		error_cnt += int'(g !== e);
		if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
	endtask : chk
	task automatic report_and_stop;
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	// reset setpoint, full write and read-back, reload by lockout
	task automatic t_regs;
		chk("sp", 12'h73A, setpoint_mv_ff);
		bkr_host_i.xfer(1'h1, 8'hFF);
		chk("up", 12'h1, step_over_limit_ff);
		chk("ack", 12'h1, reg_ack_ff);
		bkr_host_i.xfer(1'h0, 8'h00);
		chk("cfg", 12'h0FF, reg_rdata_ff);
		undervoltage_lockout = 1'h1;
		bkr_host_i.xfer(1'h1, 8'hC1);
		chk("uvlo_on", 12'h0, regulator_on_ff);
		undervoltage_lockout = 1'h0;
		bkr_host_i.xfer(1'h0, 8'h00);
		chk("cfg", 12'h025, reg_rdata_ff);
	endtask : t_regs
	// one code write; setpoint moves at once, no flag
	task automatic t_code(input logic [7:0] d, input logic [11:0] mv);
		bkr_host_i.xfer(1'h1, d);
		chk("sp", mv, setpoint_mv_ff);
		chk("up", 12'h0, step_over_limit_ff);
	endtask : t_code
	// release, keep-alive and discharge; reads serve as waits
	task automatic t_power;
		bkr_host_i.xfer(1'h1, 8'h40);
		hold_pin = 1'h0;
		bkr_host_i.xfer(1'h0, 8'h00);
		chk("on", 12'h0, regulator_on_ff);
		chk("dis", 12'h1, discharge_on_ff);
		hold_pin = 1'h1;
		bkr_host_i.xfer(1'h1, 8'hC0);
		hold_pin = 1'h0;
		bkr_host_i.xfer(1'h0, 8'h00);
		chk("on", 12'h1, regulator_on_ff);
		bkr_host_i.xfer(1'h1, 8'h00);
		bkr_host_i.xfer(1'h0, 8'h00);
		chk("on_dis", 12'h0, {regulator_on_ff, discharge_on_ff});
		hold_pin = 1'h1;
	endtask : t_power
	// 20 MHz clock
	initial begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end
	// ten cycles of reset, then the scenarios
	initial begin
		{reset, undervoltage_lockout, hold_pin, push_button_input} = 4'hB;
		repeat (10) @(posedge core_clk) #1;
		reset = 1'h0;
		t_regs;
		t_code(8'h27, 12'h79E);
		t_code(8'h20, 12'h640);
		t_code(8'h1F, 12'h627);
		t_code(8'h00, 12'h320);
		t_power;
		report_and_stop;
	end
	// hang guard, far beyond the run length
	initial begin
		#100000;
		error_cnt++;
		report_and_stop;
	end
endmodule : tb_buck_regulator_config_register
